// *** emr_mem_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// Static memory whose output enable is the read strobe itself.
module emr_mem_model
  import emr_pkg::*;
(
  // Pins from the controller.
  input  wire logic                  clk,
  input  wire logic                  slow,
  input  wire logic                  oeN,
  input  wire logic                  progSelN,
  input  wire logic [EMR_ADDR_W-1:0] addr,
  // Data lines.
  output logic      [EMR_DATA_W-1:0] data
);
  logic [EMR_DATA_W-1:0] last;
  logic                  wasHigh;
  // A slow part shows junk in the first enabled cycle; off the bus the
  // lines toggle, since nothing holds them.
  assign data = (!oeN && !(slow && wasHigh))
    ? addr[15:0] ^ (progSelN ? 16'h3c5a : 16'ha5c3) : ~last;
  // History for the junk pattern.
  always_ff @(posedge clk) begin
    last <= data;
    wasHigh <= oeN;
  end
endmodule
`default_nettype wire

// *** emr_pin_cell.sv ***
`timescale 1ns/1ps
`default_nettype none
// One upper data pin: bus function or general-purpose port function.
module emr_pin_cell
  import emr_pkg::*;
(
  // Bus side.
  input  wire logic busDrive,
  input  wire logic busOut,
  // Port side.
  input  wire logic gpSelect,
  input  wire logic gpDir,
  input  wire logic gpOut,
  // Pull-up control.
  input  wire logic pullupEnable,
  // Pad.
  output logic      padOut,
  output logic      padOe,
  output logic      padPullup
);

  // Port function overrides the bus when selected; direction 1 is output.
  always_comb begin
    if (gpSelect) begin // RULE_04
      padOe  = gpDir;
      padOut = gpOut;
    end else begin
      padOe  = busDrive; // RULE_01
      padOut = busOut;
    end
    padPullup = pullupEnable; // RULE_06
  end

endmodule
`default_nettype wire

// *** emr_pkg.sv ***
package emr_pkg;

  // Bus widths.
  localparam int EMR_DATA_W    = 16;
  localparam int EMR_UPPER_LO  = 7;
  localparam int EMR_UPPER_HI  = 15;
  localparam int EMR_UPPER_W   = EMR_UPPER_HI - EMR_UPPER_LO + 1;
  localparam int EMR_ADDR_W    = 24;
  localparam int EMR_CS_W      = 4;

  // Reset values of the loose control bits.
  localparam logic                   EMR_DRIVE_RST   = 1'h0;
  localparam logic [EMR_UPPER_W-1:0] EMR_GPSEL_RST   = 9'h000;
  localparam logic [EMR_UPPER_W-1:0] EMR_PULLUP_RST  = 9'h1ff;

  // Read cycle timing: strobe low time in clock cycles.
  localparam int EMR_CLK_MHZ       = 125;
  localparam int EMR_STROBE_NS     = 24;
  localparam int EMR_STROBE_CYC    =
    (EMR_STROBE_NS * EMR_CLK_MHZ + 999) / 1000;
  localparam int EMR_CNT_W         = 8;

  // Read cycle sequencer states.
  typedef enum logic [1:0] {
    EMR_IDLE    = 2'b00,
    EMR_TURN    = 2'b01,
    EMR_STROBE  = 2'b10,
    EMR_CAPTURE = 2'b11
  } emr_state_t;

endpackage

// *** emr_read_ctrl.sv ***
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// RULE_01: Pins 7 to 15 carry the upper part of each external data word.
// RULE_02: Upper data pins float when idle unless the idle drive bit is set; the code also floats them in an idle cycle with readReq high.
// RULE_03: Software should set the idle drive bit to one.
// RULE_04: Each upper pin may become a port pin, input or output.
// RULE_05: After reset all upper pins have their data bus function.
// RULE_06: Clearing a pin's pull-up enable bit turns its pull-up off.
// RULE_07: Read strobe is low only during external read cycles.
// RULE_08: While strobe is low all data pins are inputs; memory drives bus.
// RULE_09: Data bus is captured when the read strobe rises.
// RULE_10: Low strobe qualifies address, program/data selects and chip selects.
// RULE_11: Read strobe floats when idle unless the idle drive bit is set.
// RULE_12: Setting the control pull-up disable bit turns strobe pull-up off.
// RULE_13: Memory may take the read strobe straight on its output enable.
// RULE_14: Program memory select is chip select zero, low for program reads; the code gives it its own pin, program_mem_select_n, apart from chip_select_n.
// RULE_15: Data pins are not driven in the cycle before the strobe falls.
// RULE_16: With idle drive set, strobe and data stay driven, strobe high; the code releases the data pins in an idle cycle with readReq high.
module emr_read_ctrl
  import emr_pkg::*;
#(
  parameter int STROBE_CYC = EMR_STROBE_CYC
)
(
  // Clock and reset.
  input  wire logic                   clk,
  input  wire logic                   sys_rst,
  // Loose control bits.
  input  wire logic                   bus_idle_drive_bit,
  input  wire logic [EMR_UPPER_W-1:0] portSelect,
  input  wire logic [EMR_UPPER_W-1:0] portDir,
  input  wire logic [EMR_UPPER_W-1:0] portOut,
  input  wire logic [EMR_UPPER_W-1:0] port_f_pullup_enable,
  input  wire logic                   ctrlPullupDisable,
  // Read request from the core.
  input  wire logic                   readReq,
  input  wire logic                   readProgram,
  input  wire logic [EMR_ADDR_W-1:0]  readAddr,
  input  wire logic [EMR_CS_W-1:0]    readCsSel,
  output logic                        readReady,
  output logic                        readDone,
  output logic [EMR_DATA_W-1:0]       readData,
  // Upper and lower data pins.
  input  wire logic [EMR_UPPER_W-1:0] dataUpperIn,
  input  wire logic [EMR_DATA_W-1:0]  ext_data_bus,
  output logic [EMR_UPPER_W-1:0]      dataUpperOut,
  output logic [EMR_UPPER_W-1:0]      dataUpperOe,
  output logic [EMR_UPPER_W-1:0]      dataUpperPullup,
  output logic [EMR_UPPER_W-1:0]      portIn,
  output logic                        dataLowOe,
  // Strobe and qualified address lines.
  output logic                        readStrobeN,
  output logic                        readStrobeOe,
  output logic                        readStrobePullup,
  output logic [EMR_ADDR_W-1:0]       ext_address_bus,
  output logic                        program_mem_select_n,
  output logic                        data_mem_select_n,
  output logic [EMR_CS_W-1:0]         chip_select_n
);

  emr_state_t                 state;
  emr_state_t                 next_state;
  logic [EMR_DATA_W-1:0]      next_readData;
  logic                       next_readDone;
  logic [EMR_ADDR_W-1:0]      next_ext_address_bus;
  logic                       next_program_mem_select_n;
  logic                       next_data_mem_select_n;
  logic [EMR_CS_W-1:0]        next_chip_select_n;
  logic [EMR_ADDR_W-1:0]      latchAddr;
  logic [EMR_ADDR_W-1:0]      next_latchAddr;
  logic                       latchProgram;
  logic                       next_latchProgram;
  logic [EMR_CS_W-1:0]        latchCs;
  logic [EMR_CS_W-1:0]        next_latchCs;
  logic                       cntLoad;
  logic                       cntDone;
  logic                       busDrive;
  logic [EMR_DATA_W-1:0]      busValue;

  // Strobe width timer.
  emr_strobe_cnt #(
    .CNT_W (EMR_CNT_W)
  ) u_cnt (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .load      (cntLoad),
    .loadValue (EMR_CNT_W'(STROBE_CYC)),
    .done      (cntDone)
  );

  assign readReady = (state == EMR_IDLE);
  assign cntLoad   = (state == EMR_IDLE) && readReq;

  // Sequencer: a turnaround cycle with the bus released comes before the
  // strobe falls, so a driven idle bus never fights the memory.
  always_comb begin
    next_state        = state;
    next_readData     = readData;
    next_readDone     = 1'b0;
    next_latchAddr    = latchAddr;
    next_latchProgram = latchProgram;
    next_latchCs      = latchCs;
    case (state)
      EMR_IDLE: begin
        if (readReq) begin
          next_latchAddr    = readAddr;
          next_latchProgram = readProgram;
          next_latchCs      = readCsSel;
          next_state        = EMR_TURN; // RULE_15
        end
      end
      EMR_TURN: begin
        next_state = EMR_STROBE;
      end
      EMR_STROBE: begin
        if (cntDone) begin
          // Strobe rises at this edge while the memory still drives the
          // bus, so the word is sampled with it.
          next_readData = ext_data_bus; // RULE_09
          next_state    = EMR_CAPTURE;
        end
      end
      EMR_CAPTURE: begin
        next_readDone = 1'b1;
        next_state    = EMR_IDLE;
      end
      default: begin
        next_state = EMR_IDLE;
      end
    endcase
  end

  // Strobe and qualified selects are registered so they switch cleanly.
  always_comb begin
    next_ext_address_bus      = ext_address_bus;
    next_program_mem_select_n = 1'b1;
    next_data_mem_select_n    = 1'b1;
    next_chip_select_n        = {EMR_CS_W{1'b1}};
    if (next_state == EMR_STROBE) begin // RULE_10
      next_ext_address_bus      = next_latchAddr;
      next_program_mem_select_n = ~next_latchProgram; // RULE_14
      next_data_mem_select_n    = next_latchProgram;
      next_chip_select_n        = ~next_latchCs;
    end
  end

  logic next_readStrobeN;
  assign next_readStrobeN = (next_state != EMR_STROBE); // RULE_07

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state                <= EMR_IDLE;
      readData             <= '0;
      readDone             <= 1'b0;
      latchAddr            <= '0;
      latchProgram         <= 1'b0;
      latchCs              <= '0;
      readStrobeN          <= 1'b1;
      ext_address_bus      <= '0;
      program_mem_select_n <= 1'b1;
      data_mem_select_n    <= 1'b1;
      chip_select_n        <= {EMR_CS_W{1'b1}};
    end else begin
      state                <= next_state;
      readData             <= next_readData;
      readDone             <= next_readDone;
      latchAddr            <= next_latchAddr;
      latchProgram         <= next_latchProgram;
      latchCs              <= next_latchCs;
      readStrobeN          <= next_readStrobeN;
      ext_address_bus      <= next_ext_address_bus;
      program_mem_select_n <= next_program_mem_select_n;
      data_mem_select_n    <= next_data_mem_select_n;
      chip_select_n        <= next_chip_select_n;
    end
  end

  // Bus drives only when idle with drive set; never during a read.
  always_comb begin
    busDrive = (state == EMR_IDLE) && bus_idle_drive_bit // RULE_02 RULE_16
               && !readReq; // RULE_08
    busValue = readData;
  end

  assign dataLowOe = busDrive; // RULE_08

  // Strobe stays driven high while idle only when the drive bit is set.
  assign readStrobeOe     = (state != EMR_IDLE) || bus_idle_drive_bit; // RULE_11
  assign readStrobePullup = ~ctrlPullupDisable; // RULE_12

  // One cell per upper pin; reset of portSelect keeps bus function.
  genvar gi;
  generate
    for (gi = 0; gi < EMR_UPPER_W; gi++) begin : g_pin
      emr_pin_cell u_pin (
        .busDrive     (busDrive),
        .busOut       (busValue[EMR_UPPER_LO+gi]),
        .gpSelect     (portSelect[gi]), // RULE_05
        .gpDir        (portDir[gi]),
        .gpOut        (portOut[gi]),
        .pullupEnable (port_f_pullup_enable[gi]),
        .padOut       (dataUpperOut[gi]),
        .padOe        (dataUpperOe[gi]),
        .padPullup    (dataUpperPullup[gi])
      );
    end
  endgenerate

  assign portIn = dataUpperIn;

endmodule
`default_nettype wire

// *** emr_read_ctrl_assertions.sv ***
`timescale 1ns/1ps
`default_nettype none
// Watches the read strobe, the pin enables and the selects.
module emr_read_ctrl_assertions
  import emr_pkg::*;
#(
  parameter int STROBE_CYC = EMR_STROBE_CYC
)
(
  // Clock, reset and control.
  input wire logic                   clk,
  input wire logic                   sys_rst,
  input wire logic                   bus_idle_drive_bit,
  input wire logic                   ctrlPullupDisable,
  input wire logic                   readReq,
  input wire logic [EMR_UPPER_W-1:0] portSelect,
  input wire logic [EMR_UPPER_W-1:0] portDir,
  input wire logic [EMR_UPPER_W-1:0] port_f_pullup_enable,
  // Outputs under watch.
  input wire logic                   readReady,
  input wire logic                   readDone,
  input wire logic                   dataLowOe,
  input wire logic [EMR_UPPER_W-1:0] dataUpperOe,
  input wire logic [EMR_UPPER_W-1:0] dataUpperPullup,
  input wire logic                   readStrobeN,
  input wire logic                   readStrobeOe,
  input wire logic                   readStrobePullup,
  input wire logic                   program_mem_select_n,
  input wire logic                   data_mem_select_n
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  // Strobe timing and the capture that follows it.
  property p_low;
    $fell(readStrobeN) |-> ##STROBE_CYC $rose(readStrobeN);
  endproperty
  a_low: assert property (p_low) else $error("strobe low time wrong");
  property p_done;
    $rose(readStrobeN) |-> ##[1:2] readDone;
  endproperty
  a_done: assert property (p_done) else $error("no done");
  // The bus must be released before and while the strobe is low.
  property p_in;
    !readStrobeN |-> !dataLowOe && (dataUpperOe & ~portSelect) == '0;
  endproperty
  a_in: assert property (p_in) else $error("bus driven in read");
  property p_turn;
    $fell(readStrobeN) |-> $past(dataLowOe) == 1'b0;
  endproperty
  a_turn: assert property (p_turn) else $error("no turnaround");
  // Idle drive follows the control bit; the strobe stays high when idle.
  property p_idle;
    readReady && !readReq |-> dataLowOe == bus_idle_drive_bit
      && readStrobeOe == bus_idle_drive_bit;
  endproperty
  a_idle: assert property (p_idle) else $error("idle drive");
  property p_high;
    readReady |-> readStrobeN;
  endproperty
  a_high: assert property (p_high) else $error("strobe low idle");
  // Bus pins share the bus enable; port pins follow their direction.
  property p_bus;
    (dataUpperOe & ~portSelect) == ({EMR_UPPER_W{dataLowOe}} & ~portSelect);
  endproperty
  a_bus: assert property (p_bus) else $error("bus pin enable");
  property p_gp;
    (dataUpperOe & portSelect) == (portDir & portSelect);
  endproperty
  a_gp: assert property (p_gp) else $error("port pin enable");
  property p_pull;
    dataUpperPullup == port_f_pullup_enable
      && readStrobePullup == !ctrlPullupDisable;
  endproperty
  a_pull: assert property (p_pull) else $error("pull-up wrong");
  property p_sel;
    !readStrobeN |-> program_mem_select_n != data_mem_select_n;
  endproperty
  a_sel: assert property (p_sel) else $error("selects wrong");
  c_read: cover property ($rose(readDone));
  c_drv: cover property (readReady && bus_idle_drive_bit);
  c_port: cover property ((portSelect & portDir) != '0);
endmodule
bind emr_read_ctrl emr_read_ctrl_assertions #(.STROBE_CYC(STROBE_CYC))
  u_chk (.clk(clk), .sys_rst(sys_rst),
    .bus_idle_drive_bit(bus_idle_drive_bit),
    .ctrlPullupDisable(ctrlPullupDisable), .readReq(readReq),
    .portSelect(portSelect), .portDir(portDir),
    .port_f_pullup_enable(port_f_pullup_enable),
    .readReady(readReady), .readDone(readDone), .dataLowOe(dataLowOe),
    .dataUpperOe(dataUpperOe), .dataUpperPullup(dataUpperPullup),
    .readStrobeN(readStrobeN), .readStrobeOe(readStrobeOe),
    .readStrobePullup(readStrobePullup),
    .program_mem_select_n(program_mem_select_n),
    .data_mem_select_n(data_mem_select_n));
`default_nettype wire

// *** emr_read_ctrl_bench.sv ***
`timescale 1ns/1ps
`default_nettype none
// Drives reads and port settings and checks what comes back.
module emr_read_ctrl_bench
  import emr_pkg::*;
;
  logic clk = 1'b0;
  logic sys_rst, bus_idle_drive_bit, ctrlPullupDisable, readReq, slow;
  logic readProgram, readReady, readDone, dataLowOe, readStrobeN;
  logic readStrobeOe, readStrobePullup, program_mem_select_n;
  logic data_mem_select_n;
  logic [EMR_UPPER_W-1:0] portSelect, portDir, portOut, dataUpperIn;
  logic [EMR_UPPER_W-1:0] port_f_pullup_enable, dataUpperOut, portIn;
  logic [EMR_UPPER_W-1:0] dataUpperOe, dataUpperPullup, outPins;
  logic [EMR_ADDR_W-1:0]  readAddr, ext_address_bus;
  logic [EMR_CS_W-1:0]    readCsSel, chip_select_n;
  logic [EMR_DATA_W-1:0]  readData, ext_data_bus;
  logic [28:0]            curSel;
  logic [15:0]            expQ[$];
  logic [31:0]            seed = 32'h00000056;
  logic [31:0]            r, q;
  int                     miscompares = 0;
  int                     tests_run = 0;
  int                     cycles = 0;
  // Pad level: the pin's own driver wins, else the memory's lines.
  assign dataUpperIn = (dataUpperOe & dataUpperOut)
    | (~dataUpperOe & ext_data_bus[15:7]);
  assign outPins = portSelect & portDir;
  always #4 clk = ~clk;
  emr_read_ctrl #(.STROBE_CYC(3)) DUT (
    .clk(clk), .sys_rst(sys_rst), .bus_idle_drive_bit(bus_idle_drive_bit),
    .portSelect(portSelect), .portDir(portDir), .portOut(portOut),
    .port_f_pullup_enable(port_f_pullup_enable),
    .ctrlPullupDisable(ctrlPullupDisable), .readReq(readReq),
    .readProgram(readProgram), .readAddr(readAddr), .readCsSel(readCsSel),
    .readReady(readReady), .readDone(readDone), .readData(readData),
    .dataUpperIn(dataUpperIn), .ext_data_bus(ext_data_bus),
    .dataUpperOut(dataUpperOut), .dataUpperOe(dataUpperOe),
    .dataUpperPullup(dataUpperPullup), .portIn(portIn),
    .dataLowOe(dataLowOe), .readStrobeN(readStrobeN),
    .readStrobeOe(readStrobeOe), .readStrobePullup(readStrobePullup),
    .ext_address_bus(ext_address_bus),
    .program_mem_select_n(program_mem_select_n),
    .data_mem_select_n(data_mem_select_n), .chip_select_n(chip_select_n));
  emr_mem_model MEM (.clk(clk), .slow(slow), .oeN(readStrobeN),
    .progSelN(program_mem_select_n), .addr(ext_address_bus),
    .data(ext_data_bus));
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic note(input logic ok, input string what);
    tests_run++;
    if (!ok) begin
      miscompares++;
      $display("unexpected at %0t: %s", $time, what);
    end
  endtask
  task automatic cmp_data(input logic [15:0] got, exp);
    note(got === exp, "read data");
  endtask
  task automatic cmp_pin(input logic [31:0] got, exp);
    note(got === exp, "pin state");
  endtask
  task automatic complete_run();
    $display("miscompares %0d tests_run %0d", miscompares, tests_run);
    if (miscompares == 0 && tests_run > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // A request held while the block is busy must simply wait.
  task automatic do_read(input logic p, input logic [23:0] a,
                         input logic [3:0] cs);
    @(posedge clk);
    {readReq, readProgram, readAddr, readCsSel} <= {1'b1, p, a, cs};
    expQ.push_back(a[15:0] ^ (p ? 16'ha5c3 : 16'h3c5a));
    do @(posedge clk); while (readReady !== 1'b1);
    readReq <= 1'b0;
    curSel <= {~cs, ~p, a};
  endtask
  task automatic chk_reset();
    @(negedge clk);
    cmp_pin({5'h0, readStrobeN, readStrobeOe, dataUpperOe, readData},
            {5'h0, 2'h2, 9'h000, 16'h0000});
  endtask
  // Results are taken in order against the driver's notes.
  always @(posedge clk) begin
    if (readDone === 1'b1)
      cmp_data(readData, expQ.size() ? expQ.pop_front() : 16'hxxxx);
    if (readStrobeN === 1'b0)
      cmp_pin({3'h0, chip_select_n, program_mem_select_n, ext_address_bus},
              {3'h0, curSel});
    // The ceiling is far above the hundred or so cycles the scenarios need.
    cycles++;
    if (cycles == 2000) begin
      miscompares++;
      complete_run();
    end
  end
  initial begin
    {bus_idle_drive_bit, ctrlPullupDisable, readReq, readProgram} = '0;
    {slow, readAddr, readCsSel, portSelect, portDir, portOut} = '0;
    {port_f_pullup_enable, curSel} = '0;
    sys_rst = 1'b1;
    repeat (12) @(posedge clk);
    sys_rst <= 1'b0;
    chk_reset();
    // Back-to-back reads under random port and pull-up settings, with idle drive alternating.
    for (int i = 0; i < 12; i++) begin
      @(posedge clk);
      r = xs();
      q = xs();
      bus_idle_drive_bit <= i[0];
      slow <= i[1];
      {portSelect, portDir, portOut} <= r[26:0];
      {ctrlPullupDisable, port_f_pullup_enable} <= q[31:22];
      do_read(r[27], q[23:0], 4'h1 << r[29:28]);
      @(negedge clk);
      cmp_pin({13'h0, readStrobePullup, dataUpperPullup, portIn & outPins},
        {13'h0, ~ctrlPullupDisable, port_f_pullup_enable,
         portOut & outPins});
    end
    wait (expQ.size() == 0);
    @(posedge clk);
    {bus_idle_drive_bit, portSelect, sys_rst} <= {10'h000, 1'b1};
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    chk_reset();
    do_read(1'b0, 24'h00ffff, 4'h8);
    wait (expQ.size() == 0);
    repeat (2) @(posedge clk);
    complete_run();
  end
endmodule
`default_nettype wire

// *** emr_strobe_cnt.sv ***
`timescale 1ns/1ps
`default_nettype none
// Down counter that times the strobe-low phase of a read.
module emr_strobe_cnt
  import emr_pkg::*;
#(
  parameter int CNT_W = EMR_CNT_W
)
(
  // Clock and reset.
  input  wire logic clk,
  input  wire logic sys_rst,
  // Control.
  input  wire logic load,
  input  wire logic [CNT_W-1:0] loadValue,
  // Status.
  output logic      done
);

  logic [CNT_W-1:0] count;
  logic [CNT_W-1:0] next_count;

  // Load wins over counting so a new cycle always gets full width.
  always_comb begin
    if (load) begin
      next_count = loadValue;
    end else if (count != '0) begin
      next_count = count - 1'b1;
    end else begin
      next_count = count;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      count <= '0;
    end else begin
      count <= next_count;
    end
  end

  // Done only once the count has run out, so the strobe stays low for
  // exactly the loaded number of cycles.
  assign done = (count == '0);

endmodule
`default_nettype wire
